/* File: shared/standby_mode_control_map.vh */
// constants for the standby and oscillator gating controller
`ifndef STANDBY_MODE_CONTROL_MAP_VH
`define STANDBY_MODE_CONTROL_MAP_VH

// mode request codes on i_mode_req
`define MODE_RUN            2'h0
`define MODE_HALT           2'h1
`define MODE_HOLD           2'h2
`define MODE_XTAL_HOLD      2'h3

// system clock source select codes
`define SRC_RC              2'h0
`define SRC_CERAMIC         2'h1
`define SRC_CRYSTAL         2'h2

// oscillator enable bit positions on o_osc_enable
`define OSC_BIT_RC          0
`define OSC_BIT_CERAMIC     1
`define OSC_BIT_CRYSTAL     2
`define OSC_BIT_PLL         3

// oscillator settle time in us and in 50 ns cycles
`define SETTLE_TIME_US      100
`define CLOCK_MHZ           20
`define SETTLE_CYCLES       (`SETTLE_TIME_US * `CLOCK_MHZ)

`endif

/* File: verilog/pin_sync.v */
// three-stage synchroniser for pin inputs
`default_nettype none

module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             i_clock,
    input  wire             i_rstn,
    input  wire [WIDTH-1:0] i_async,
    output reg  [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] stage_a;
    reg [WIDTH-1:0] stage_b;
    reg [WIDTH-1:0] stage_c;

    genvar n;
    generate
        for (n = 0; n < WIDTH; n = n + 1)
        begin : g_bit
            always @(posedge i_clock)
            begin
                if (!i_rstn)
                begin
                    stage_a[n] <= 1'b0;
                    stage_b[n] <= 1'b0;
                    stage_c[n] <= 1'b0;
                    o_sync[n]  <= 1'b0;
                end
                else
                begin
                    stage_a[n] <= i_async[n];
                    stage_b[n] <= stage_a[n];
                    stage_c[n] <= stage_b[n];
                    if (stage_b[n] == stage_c[n])
                        o_sync[n] <= stage_c[n];
                end
            end
        end
    endgenerate

endmodule // pin_sync

`default_nettype wire

/* File: verilog/standby_mode_control.v */
// standby mode sequencer with oscillator gating and wake-up sources
`include "standby_mode_control_map.vh"
`default_nettype none

// Functional notes
// - halt stops instruction execution; peripherals keep their clocks
// - halt entry leaves every oscillator in its previous state
// - halt ends on system reset or any interrupt request
// - hold stops execution, peripherals, pll, ceramic, rc and crystal oscillators
// - hold wakes on reset pin, external irq level, port 0, usb bus active
// - crystal hold stops execution and peripherals except the base timer
// - crystal hold entry stops pll, ceramic and rc oscillators
// - crystal hold keeps crystal oscillator in its entry state
// - crystal hold wakes on hold sources plus base timer and infrared
// - system clock from rc, ceramic or crystal; pll only for usb and audio
module standby_mode_control #(
    parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input  wire       i_clock,
    input  wire       i_rstn,
    input  wire       i_reset_pin_low_active_n,
    input  wire [1:0] i_mode_req,
    input  wire       i_mode_req_valid,
    input  wire [1:0] i_sysclk_select,
    input  wire       i_crystal_run_req,
    input  wire       i_pll_run_req,
    input  wire       i_any_irq,
    input  wire       i_ext_irq_in_a,
    input  wire       i_ext_irq_in_b,
    input  wire       i_ext_irq_in_c,
    input  wire       i_ext_irq_in_e,
    input  wire       i_ext_irq_in_f,
    input  wire [4:0] i_ext_irq_level,
    input  wire       i_port0_irq,
    input  wire       i_usb_bus_active_irq,
    input  wire       i_base_timer_irq,
    input  wire       i_infrared_irq,
    output reg        o_cpu_run,
    output reg        o_periph_clock_en,
    output reg        o_base_timer_clock_en,
    output reg  [3:0] o_osc_enable,
    output reg  [1:0] o_sysclk_select,
    output reg        o_system_reset,
    output reg  [2:0] o_state
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [4:0] ST_RUN    = 5'h01;
    localparam [4:0] ST_HALT   = 5'h02;
    localparam [4:0] ST_HOLD   = 5'h04;
    localparam [4:0] ST_XHOLD  = 5'h08;
    localparam [4:0] ST_SETTLE = 5'h10;
    localparam       CW        = 32;

    reg  [4:0]    state;
    reg  [4:0]    next_state;
    reg  [CW-1:0] settle_count;
    reg  [CW-1:0] next_settle_count;
    reg  [3:0]    osc_en;
    reg  [3:0]    next_osc_en;
    reg  [1:0]    clk_sel;
    wire [4:0]    ext_pins_sync;
    wire          reset_pin_sync;
    wire [4:0]    ext_hit;
    wire          hold_wake;
    wire          xhold_wake;
    wire          reset_pin_active;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pin_sync #(
        .WIDTH (6)
    ) u_pin_sync (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_async ({~i_reset_pin_low_active_n, i_ext_irq_in_f, i_ext_irq_in_e,
                   i_ext_irq_in_c, i_ext_irq_in_b, i_ext_irq_in_a}),
        .o_sync  ({reset_pin_sync, ext_pins_sync})
    );

    // ------------------------------------------------------------
    // wake-up sources
    // ------------------------------------------------------------
    assign reset_pin_active = reset_pin_sync;
    assign ext_hit          = ~(ext_pins_sync ^ i_ext_irq_level);
    assign hold_wake        = (|ext_hit) | i_port0_irq | i_usb_bus_active_irq;
    assign xhold_wake       = hold_wake | i_base_timer_irq | i_infrared_irq;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always @*
    begin
        next_state        = state;
        next_settle_count = settle_count;
        next_osc_en       = osc_en;
        case (state)
            ST_RUN:
            begin
                next_osc_en[`OSC_BIT_RC]      = osc_en[`OSC_BIT_RC] |
                                                (clk_sel == `SRC_RC);
                next_osc_en[`OSC_BIT_CERAMIC] = osc_en[`OSC_BIT_CERAMIC] |
                                                (clk_sel == `SRC_CERAMIC);
                next_osc_en[`OSC_BIT_CRYSTAL] = i_crystal_run_req |
                                                (clk_sel == `SRC_CRYSTAL);
                next_osc_en[`OSC_BIT_PLL]     = i_pll_run_req;
                if (i_mode_req_valid)
                begin
                    case (i_mode_req)
                        `MODE_HALT:
                            next_state = ST_HALT;
                        `MODE_HOLD:
                        begin
                            next_state  = ST_HOLD;
                            next_osc_en = 4'h0;
                        end
                        `MODE_XTAL_HOLD:
                        begin
                            next_state                    = ST_XHOLD;
                            next_osc_en[`OSC_BIT_RC]      = 1'b0;
                            next_osc_en[`OSC_BIT_CERAMIC] = 1'b0;
                            next_osc_en[`OSC_BIT_PLL]     = 1'b0;
                        end
                        default:
                            next_state = ST_RUN;
                    endcase
                end
            end
            ST_HALT:
                if (i_any_irq)
                    next_state = ST_RUN;
            ST_HOLD, ST_XHOLD:
                if ((state == ST_HOLD) ? hold_wake : xhold_wake)
                begin
                    next_state                    = ST_SETTLE;
                    next_settle_count             = SETTLE_CYCLES - 1;
                    next_osc_en[`OSC_BIT_RC]      = 1'b1;
                    next_osc_en[`OSC_BIT_CERAMIC] = 1'b1;
                    next_osc_en[`OSC_BIT_CRYSTAL] = osc_en[`OSC_BIT_CRYSTAL] |
                                                    (clk_sel == `SRC_CRYSTAL);
                end
            ST_SETTLE:
                if (settle_count == {CW{1'b0}})
                    next_state = ST_RUN;
                else
                    next_settle_count = settle_count - 1'b1;
            default:
                next_state = ST_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // state registers; reset pin acts as system reset
    // ------------------------------------------------------------
    always @(posedge i_clock)
    begin
        if (!i_rstn || reset_pin_active)
        begin
            state        <= ST_RUN;
            settle_count <= {CW{1'b0}};
            osc_en       <= 4'h1;
            clk_sel      <= `SRC_RC;
        end
        else
        begin
            state        <= next_state;
            settle_count <= next_settle_count;
            osc_en       <= next_osc_en;
            if (state == ST_RUN && i_sysclk_select != 2'h3)
                clk_sel <= i_sysclk_select;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            o_cpu_run             <= 1'b0;
            o_periph_clock_en     <= 1'b0;
            o_base_timer_clock_en <= 1'b0;
            o_osc_enable          <= 4'h0;
            o_sysclk_select       <= `SRC_RC;
            o_system_reset        <= 1'b1;
            o_state               <= 3'h0;
        end
        else if (reset_pin_active)
        begin
            o_cpu_run             <= 1'b0;
            o_periph_clock_en     <= 1'b0;
            o_base_timer_clock_en <= 1'b0;
            o_osc_enable          <= 4'h1;
            o_sysclk_select       <= `SRC_RC;
            o_system_reset        <= 1'b1;
            o_state               <= 3'h0;
        end
        else
        begin
            o_cpu_run             <= (next_state == ST_RUN);
            o_periph_clock_en     <= (next_state == ST_RUN) || (next_state == ST_HALT);
            o_base_timer_clock_en <= (next_state != ST_HOLD) && (next_state != ST_SETTLE);
            o_osc_enable          <= next_osc_en;
            o_sysclk_select       <= clk_sel;
            o_system_reset        <= 1'b0;
            case (next_state)
                ST_HALT:   o_state <= 3'h1;
                ST_HOLD:   o_state <= 3'h2;
                ST_XHOLD:  o_state <= 3'h3;
                ST_SETTLE: o_state <= 3'h4;
                default:   o_state <= 3'h0;
            endcase
        end
    end

endmodule // standby_mode_control

`default_nettype wire

/* File: verification/standby_mode_control_assertions.sv */
// port-level assertions for the standby mode controller
`default_nettype none
module standby_mode_control_assertions #(
    parameter SETTLE_CYCLES = 8
) (
    input wire logic       i_clock,
    input wire logic       i_rstn,
    input wire logic       i_any_irq,
    input wire logic       i_port0_irq,
    input wire logic       i_usb_bus_active_irq,
    input wire logic       i_base_timer_irq,
    input wire logic       i_infrared_irq,
    input wire logic       o_cpu_run,
    input wire logic       o_periph_clock_en,
    input wire logic       o_base_timer_clock_en,
    input wire logic [3:0] o_osc_enable,
    input wire logic [2:0] o_state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);
    a_halt_cpu_gate: assert property (
        o_state == 3'h1 |-> !o_cpu_run && o_periph_clock_en) else $error("halt gating");
    a_halt_irq_wake: assert property (
        o_state == 3'h1 && i_any_irq |=> o_state == 3'h0 && o_cpu_run) else $error("halt wake");
    a_hold_all_off: assert property (
        o_state == 3'h2 |-> {o_cpu_run, o_periph_clock_en, o_osc_enable} == 6'h0)
        else $error("hold gating");
    a_hold_wake_src: assert property (
        o_state == 3'h2 && (i_port0_irq || i_usb_bus_active_irq) |=> o_state == 3'h4)
        else $error("hold wake");
    a_xhold_timer_on: assert property (
        o_state == 3'h3 |-> o_base_timer_clock_en && !o_periph_clock_en && !o_cpu_run)
        else $error("crystal hold gating");
    a_xhold_osc_off: assert property (
        o_state == 3'h3 |-> !o_osc_enable[3] && o_osc_enable[1:0] == 2'h0)
        else $error("crystal hold oscillators");
    a_xhold_xtal_kept: assert property (
        o_state == 3'h3 && $past(o_state) == 3'h3 |-> $stable(o_osc_enable[2]))
        else $error("crystal hold crystal state");
    a_xhold_wake_src: assert property (
        o_state == 3'h3 && (i_base_timer_irq || i_infrared_irq || i_port0_irq
        || i_usb_bus_active_irq) |=> o_state == 3'h4) else $error("crystal hold wake");
    a_settle_resume: assert property (
        $rose(o_state == 3'h4) |-> (!o_cpu_run && o_osc_enable[0])[*6] ##[1:4] o_cpu_run)
        else $error("settle resume");
endmodule // standby_mode_control_assertions
bind standby_mode_control standby_mode_control_assertions #(.SETTLE_CYCLES(SETTLE_CYCLES))
    standby_mode_control_assertions_i (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_any_irq(i_any_irq), .i_port0_irq(i_port0_irq), .i_infrared_irq(i_infrared_irq),
    .i_usb_bus_active_irq(i_usb_bus_active_irq), .i_base_timer_irq(i_base_timer_irq),
    .o_cpu_run(o_cpu_run), .o_periph_clock_en(o_periph_clock_en), .o_state(o_state),
    .o_base_timer_clock_en(o_base_timer_clock_en), .o_osc_enable(o_osc_enable));
`default_nettype wire

/* File: verification/wake_source_model.sv */
// wake source model: a raised request stays until the cpu runs again
`default_nettype none
module wake_source_model (
    input  wire logic       i_clock,
    input  wire logic       i_go,
    input  wire logic [1:0] i_pick,
    input  wire logic       i_cpu_run,
    output var  logic [3:0] o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_irq = 4'h0;
    // bit 0 port 0, 1 usb bus active, 2 base timer, 3 infrared
    always @(posedge i_clock)
        if (i_cpu_run)
            o_irq <= 4'h0;
        else if (i_go)
            o_irq[i_pick] <= 1'b1;
endmodule // wake_source_model
`default_nettype wire

/* File: verification/standby_mode_control_tb.sv */
// self-checking bench for the standby mode controller
`include "standby_mode_control_map.vh"
`default_nettype none
module standby_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rstn, pin_n, vld, crys, go;
    logic [1:0] mode, sel, pick;
    logic [4:0] ext, lvl;
    wire  [3:0] irq, osc;
    wire  [2:0] st;
    wire  [1:0] so;
    wire        cpu, per, bt, srst;
    int         err_total, total_checks;
    standby_mode_control #(.SETTLE_CYCLES(8)) standby_mode_control_i (.i_clock(clk),
        .i_rstn(rstn), .i_reset_pin_low_active_n(pin_n), .i_mode_req(mode),
        .i_mode_req_valid(vld), .i_sysclk_select(sel), .i_crystal_run_req(crys),
        .i_pll_run_req(crys), .i_any_irq(|irq), .i_ext_irq_in_a(ext[0]),
        .i_ext_irq_in_b(ext[1]), .i_ext_irq_in_c(ext[2]), .i_ext_irq_in_e(ext[3]),
        .i_ext_irq_in_f(ext[4]), .i_ext_irq_level(lvl), .i_port0_irq(irq[0]),
        .i_usb_bus_active_irq(irq[1]), .i_base_timer_irq(irq[2]), .i_infrared_irq(irq[3]),
        .o_cpu_run(cpu), .o_periph_clock_en(per), .o_base_timer_clock_en(bt),
        .o_osc_enable(osc), .o_sysclk_select(so), .o_system_reset(srst), .o_state(st));
    wake_source_model wake_source_model_i (.i_clock(clk), .i_go(go), .i_pick(pick),
        .i_cpu_run(cpu), .o_irq(irq));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #400000;
        err_total++;
        results();
    end
    task automatic results();
        if (err_total == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic enter(input logic [1:0] m);
        {vld, mode} = {1'b1, m};
        tick(1);
        vld = 1'b0;
        tick(1);
    endtask
    task automatic wake(input logic [1:0] p);
        {go, pick} = {1'b1, p};
        tick(1);
        go = 1'b0;
    endtask
    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 40 && st !== s; i++)
            tick(1);
    endtask
    task automatic t_halt();
        logic [3:0] o;
        for (int s = 0; s < 3; s++)
        begin
            sel = s[1:0];
            tick(3);
            chk({so, osc[so]}, {s[1:0], 1'b1});
        end
        sel = 2'h3;
        tick(3);
        chk(so, `SRC_CRYSTAL);
        enter(`MODE_RUN);
        chk({cpu, st}, 4'h8);
        o = osc;
        enter(`MODE_HALT);
        chk({cpu, per, bt, st}, 6'h19);
        enter(`MODE_HOLD);
        chk({osc, st}, {o, 3'h1});
        wake(2'h3);
        tick(1);
        chk({cpu, st}, 4'h8);
    endtask
    task automatic t_hold(input int src);
        logic lo;
        lo = (src == 1 || src == 3);
        if (lo)
        begin
            {ext[src], lvl[src]} = 2'b10;
            tick(4);
        end
        enter(`MODE_HOLD);
        chk({cpu, per, bt, osc, st}, 12'h2);
        wake(2'h2);
        tick(4);
        chk(st, 3'h2);
        if (src < 5)
            ext[src] = !lo;
        else
            wake(2'(src - 5));
        wait_st(3'h4);
        chk({cpu, osc[0], st}, 5'h0c);
        {ext, lvl} = {5'h0, 5'h1f};
        wait_st(3'h0);
        chk({cpu, per}, 2'h3);
    endtask
    task automatic t_xhold(input logic [1:0] p, input logic c);
        crys = c;
        tick(2);
        enter(`MODE_XTAL_HOLD);
        chk({cpu, per, bt, osc, st}, {3'h1, 1'b0, c, 5'h3});
        crys = !c;
        tick(2);
        chk(osc[2], c);
        wake(p);
        wait_st(3'h4);
        chk({cpu, st}, 4'h4);
        wait_st(3'h0);
        chk(cpu, 1'b1);
    endtask
    task automatic t_pin();
        enter(`MODE_HOLD);
        pin_n = 1'b0;
        tick(6);
        chk({srst, osc, st}, 8'h88);
        pin_n = 1'b1;
        tick(6);
        chk({srst, cpu}, 2'h1);
    endtask
    initial
    begin
        {rstn, vld, crys, go, mode, sel, pick, ext} = '0;
        {pin_n, lvl} = {1'b1, 5'h1f};
        tick(5);
        rstn = 1'b1;
        tick(6);
        crys = 1'b1;
        t_halt();
        {sel, crys} = {`SRC_RC, 1'b0};
        for (int s = 0; s < 7; s++)
            t_hold(s);
        for (int s = 0; s < 4; s++)
            t_xhold(s[1:0], s[0]);
        t_pin();
        results();
    end
endmodule // standby_mode_control_tb
`default_nettype wire
